//--- src/line_ctrl_defines.vh
// register map, widths and reset values of the parallel line controller
`ifndef LINE_CTRL_DEFINES_VH
`define LINE_CTRL_DEFINES_VH
`define LC_W 32
`define LC_AW 8
`define LC_GRANT 8'h00
`define LC_RELEASE 8'h04
`define LC_CTRL_STATE 8'h08
`define LC_DRV_EN 8'h10
`define LC_DRV_DIS 8'h14
`define LC_DRV_STATE 8'h18
`define LC_FLT_EN 8'h20
`define LC_FLT_DIS 8'h24
`define LC_FLT_STATE 8'h28
`define LC_LVL_SET 8'h30
`define LC_LVL_CLR 8'h34
`define LC_LVL_STATE 8'h38
`define LC_PIN_SAMPLE 8'h3C
`define LC_IRQ_EN 8'h40
`define LC_IRQ_DIS 8'h44
`define LC_IRQ_MASK 8'h48
`define LC_IRQ_STATUS 8'h4C
`define LC_DW_EN 8'hA0
`define LC_DW_DIS 8'hA4
`define LC_DW_STATE 8'hA8
`define LC_ZERO 32'h0000_0000
`define LC_IMPL_DEFAULT 32'hFFFF_FFFF
`define LC_MUXED_DEFAULT 32'hFFFF_FFFF
`define LC_FLT_LEN 2
`endif

//--- src/parallel_line_controller.v
// parallel line controller: ownership, drive, level, filter and change irq
`timescale 1ns/1ps
`default_nettype none
`include "line_ctrl_defines.vh"
module parallel_line_controller #(
  parameter [31:0] IMPL_LINES = `LC_IMPL_DEFAULT,
  parameter [31:0] MUXED_LINES = `LC_MUXED_DEFAULT
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [31:0] pin_in,
  output reg [31:0] pin_out,
  output reg [31:0] pin_oe,
  output reg [31:0] periph_sel,
  input wire [31:0] periph_out,
  input wire [31:0] periph_oe,
  output reg [31:0] line_in,
  output reg irq
);
  reg [31:0] own_q;
  reg [31:0] drv_q;
  reg [31:0] flt_q;
  reg [31:0] lvl_q;
  reg [31:0] imr_q;
  reg [31:0] isr_q;
  reg [31:0] dw_q;
  reg [31:0] sync1_q;
  reg [31:0] sync2_q;
  reg [31:0] filt_q;
  reg [31:0] prev_q;
  reg [31:0] rdata_d;
  reg rdy_q;
  wire [31:0] mask;
  wire wr;
  wire rd;
  wire [31:0] wd;
  wire [31:0] change;
  wire [`LC_AW-1:0] a;

  // one wait state: setup, access, answer with pready on second access cycle
  assign pready = rdy_q;
  assign pslverr = 1'b0;
  assign a = paddr[`LC_AW-1:0];
  assign wr = psel & penable & pwrite & rdy_q;
  assign rd = psel & penable & ~pwrite & rdy_q;
  assign mask = IMPL_LINES;
  assign wd = pwdata & mask;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= psel & penable & ~rdy_q;
    end
  end

  // two-stage synchroniser per pad; only the second stage feeds logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= `LC_ZERO;
    end else begin
      sync1_q <= pin_in;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync2_q <= `LC_ZERO;
    end else begin
      sync2_q <= sync1_q;
    end
  end

  // one more sample of the synchronised level, for the stability test
  // reading the first stage here would let metastability leak in
  reg [31:0] hist_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_q <= `LC_ZERO;
    end else begin
      hist_q <= sync2_q;
    end
  end

  // filter per line: level must match over LC_FLT_LEN samples
  // a pulse shorter than that never reaches the filtered level
  // costs one cycle of latency on filtered lines only
  genvar i;
  generate
    for (i = 0; i < `LC_W; i = i + 1) begin : g_line
      wire same;
      assign same = (sync2_q[i] == hist_q[i]);
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          filt_q[i] <= 1'b0;
        end else if (!flt_q[i]) begin
          filt_q[i] <= sync2_q[i];
        end else if (same) begin
          filt_q[i] <= sync2_q[i];
        end
      end
    end
  endgenerate

  assign change = (filt_q ^ prev_q) & mask;

  // register strobes, one per write address plus the status read, all on the answer edge
  // writes to read-only or reserved addresses decode to nothing
  wire wr_grant;
  wire wr_release;
  wire wr_drv_en;
  wire wr_drv_dis;
  wire wr_flt_en;
  wire wr_flt_dis;
  wire wr_lvl_set;
  wire wr_lvl_clr;
  wire wr_lvl_state;
  wire wr_irq_en;
  wire wr_irq_dis;
  wire wr_dw_en;
  wire wr_dw_dis;
  wire rd_status;

  assign wr_grant = wr & (a == `LC_GRANT);
  assign wr_release = wr & (a == `LC_RELEASE);
  assign wr_drv_en = wr & (a == `LC_DRV_EN);
  assign wr_drv_dis = wr & (a == `LC_DRV_DIS);
  assign wr_flt_en = wr & (a == `LC_FLT_EN);
  assign wr_flt_dis = wr & (a == `LC_FLT_DIS);
  assign wr_lvl_set = wr & (a == `LC_LVL_SET);
  assign wr_lvl_clr = wr & (a == `LC_LVL_CLR);
  assign wr_lvl_state = wr & (a == `LC_LVL_STATE);
  assign wr_irq_en = wr & (a == `LC_IRQ_EN);
  assign wr_irq_dis = wr & (a == `LC_IRQ_DIS);
  assign wr_dw_en = wr & (a == `LC_DW_EN);
  assign wr_dw_dis = wr & (a == `LC_DW_DIS);
  assign rd_status = rd & (a == `LC_IRQ_STATUS);

  // previous filtered level, the reference for change detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= `LC_ZERO;
    end else begin
      prev_q <= filt_q;
    end
  end

  // ownership: a set bit hands the pad to the line controller
  // reset leaves every muxed line with its peripheral
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_q <= `LC_ZERO;
    end else if (wr_grant) begin
      own_q <= own_q | wd;
    end else if (wr_release) begin
      own_q <= own_q & ~wd;
    end
  end

  // output driver enable per line
  // only reaches the pad on lines the controller owns
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_q <= `LC_ZERO;
    end else if (wr_drv_en) begin
      drv_q <= drv_q | wd;
    end else if (wr_drv_dis) begin
      drv_q <= drv_q & ~wd;
    end
  end

  // glitch filter enable per line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_q <= `LC_ZERO;
    end else if (wr_flt_en) begin
      flt_q <= flt_q | wd;
    end else if (wr_flt_dis) begin
      flt_q <= flt_q & ~wd;
    end
  end

  // scheduled output level; set and clear never touch other lines
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q <= `LC_ZERO;
    end else if (wr_lvl_set) begin
      lvl_q <= lvl_q | wd;
    end else if (wr_lvl_clr) begin
      lvl_q <= lvl_q & ~wd;
    end else if (wr_lvl_state) begin
      // direct write only on lines opened for it
      lvl_q <= (lvl_q & ~dw_q) | (wd & dw_q);
    end
  end

  // change interrupt mask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imr_q <= `LC_ZERO;
    end else if (wr_irq_en) begin
      imr_q <= imr_q | wd;
    end else if (wr_irq_dis) begin
      imr_q <= imr_q & ~wd;
    end
  end

  // lines on which direct level writes are allowed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dw_q <= `LC_ZERO;
    end else if (wr_dw_en) begin
      dw_q <= dw_q | wd;
    end else if (wr_dw_dis) begin
      dw_q <= dw_q & ~wd;
    end
  end

  // read clears only what was reported; a change in the same cycle
  // survives, so no edge is lost between capture and clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isr_q <= `LC_ZERO;
    end else if (rd_status) begin
      isr_q <= (isr_q & ~prdata) | change;
    end else begin
      isr_q <= isr_q | change;
    end
  end

  // read views, unimplemented lines forced to zero
  wire [31:0] ctrl_view;
  wire [31:0] drv_view;
  wire [31:0] flt_view;
  wire [31:0] lvl_view;
  wire [31:0] pin_view;
  wire [31:0] imr_view;
  wire [31:0] isr_view;
  wire [31:0] dw_view;

  // lines without a peripheral always read as owned
  assign ctrl_view = (own_q | ~MUXED_LINES) & mask;
  assign drv_view = drv_q & mask;
  assign flt_view = flt_q & mask;
  assign lvl_view = lvl_q & mask;
  assign pin_view = filt_q & mask;
  assign imr_view = imr_q & mask;
  assign isr_view = isr_q & mask;
  assign dw_view = dw_q & mask;

  always @* begin
    case (a)
      `LC_CTRL_STATE: rdata_d = ctrl_view;
      `LC_DRV_STATE: rdata_d = drv_view;
      `LC_FLT_STATE: rdata_d = flt_view;
      `LC_LVL_STATE: rdata_d = lvl_view;
      `LC_PIN_SAMPLE: rdata_d = pin_view;
      `LC_IRQ_MASK: rdata_d = imr_view;
      `LC_IRQ_STATUS: rdata_d = isr_view;
      `LC_DW_STATE: rdata_d = dw_view;
      default: rdata_d = `LC_ZERO;
    endcase
  end

  // next values of the outputs, registered below
  wire [31:0] pin_out_d;
  wire [31:0] pin_oe_d;
  wire [31:0] periph_sel_d;
  wire irq_d;
  wire [31:0] prdata_d;
  wire rd_first;

  // owned lines driven from our level, others from the peripheral
  assign pin_out_d = (own_q & lvl_q) | (~own_q & periph_out);
  assign pin_oe_d = ((own_q & drv_q) | (~own_q & periph_oe)) & mask;
  assign periph_sel_d = ~ctrl_view & mask;
  assign irq_d = |(isr_q & imr_q);
  // read data only in the cycle pready stands, zero otherwise
  assign rd_first = psel & penable & ~pwrite & ~rdy_q;
  assign prdata_d = rd_first ? rdata_d : `LC_ZERO;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `LC_ZERO;
    end else begin
      prdata <= prdata_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= `LC_ZERO;
    end else begin
      pin_out <= pin_out_d;
    end
  end

  // drivers stay off through reset, so no pad is fought at power up
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe <= `LC_ZERO;
    end else begin
      pin_oe <= pin_oe_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_sel <= `LC_ZERO;
    end else begin
      periph_sel <= periph_sel_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_in <= `LC_ZERO;
    end else begin
      line_in <= filt_q;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end
endmodule
`default_nettype wire

//--- verification/line_ctrl_monitor.sv
// port-level assertions for the parallel line controller
`timescale 1ns/1ps
`default_nettype none
`include "line_ctrl_defines.vh"
module line_ctrl_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [31:0] pin_out,
  input wire [31:0] periph_sel
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr_ok = psel && penable && pready && pwrite;
  wire [7:0] a = paddr[7:0];
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_ready_cause: assert property ($rose(pready) |-> $past(penable))
    else $error("ready without access");
  a_no_error: assert property (!pslverr) else $error("slave error");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
    else $error("stray read data");
  a_gap_zero: assert property (
    pready && !pwrite && a == 8'h0C |-> prdata == 32'h0) else $error("gap");
  a_grant_takes: assert property (wr_ok && a == `LC_GRANT |->
    ##2 (periph_sel & $past(pwdata, 2)) == 32'h0) else $error("grant lost");
  a_release_gives: assert property (wr_ok && a == `LC_RELEASE |->
    ##2 (~periph_sel & $past(pwdata, 2)) == 32'h0) else $error("release");
  a_clear_low: assert property (wr_ok && a == `LC_LVL_CLR |->
    ##2 (pin_out & ~periph_sel & $past(pwdata, 2)) == 32'h0)
    else $error("level clear lost");
endmodule
bind parallel_line_controller line_ctrl_monitor u_line_ctrl_monitor (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .pin_out, .periph_sel);
`default_nettype wire

//--- verification/pad_model.sv
// pads and peripheral standing at the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module pad_model (
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] ext,
  output logic [31:0] pin_in,
  output logic [31:0] periph_out,
  output logic [31:0] periph_oe
);
  // undriven pads follow what the outside world puts on them
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
  // peripheral drivers off, else pad levels would be ambiguous
  assign periph_out = 32'hA5A5_5A5A;
  assign periph_oe = 32'h0;
endmodule
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the parallel line controller
`timescale 1ns/1ps
`default_nettype none
`include "line_ctrl_defines.vh"
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, ext = 0, rd;
  wire [31:0] prdata, pin_in, pin_out, pin_oe, periph_sel;
  wire [31:0] periph_out, periph_oe, line_in;
  wire pready, pslverr, irq;
  int error_cnt = 0, samples_checked = 0;
  always #10 pclk = ~pclk;
  parallel_line_controller u_parallel_line_controller (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pin_in, .pin_out, .pin_oe, .periph_sel, .periph_out, .periph_oe,
    .line_in, .irq);
  pad_model u_pad_model (.pin_out, .pin_oe, .ext, .pin_in, .periph_out,
    .periph_oe);
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // three idle edges after each transfer let its effect reach the outputs
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0;
    penable <= 0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(nm, rd, e);
  endtask
  task automatic t_reset;
    rc("ctrl", `LC_CTRL_STATE, 0);
    rc("drive", `LC_DRV_STATE, 0);
    rc("filter", `LC_FLT_STATE, 0);
    rc("level", `LC_LVL_STATE, 0);
  endtask
  task automatic t_own;
    apb(1, `LC_GRANT, 32'hFF);
    apb(1, `LC_CTRL_STATE, 32'hFFFF_0000);
    apb(1, `LC_RELEASE, 32'h0F);
    rc("ctrl", `LC_CTRL_STATE, 32'hF0);
    chk("sel", periph_sel[7:0], 8'h0F);
    chk("mux", pin_out[3:0], 4'hA);
    apb(1, `LC_DRV_EN, 32'hFF);
    apb(1, `LC_DRV_DIS, 32'h0F);
    rc("drive", `LC_DRV_STATE, 32'hF0);
    chk("oe", pin_oe, 32'hF0);
    apb(1, `LC_FLT_EN, 32'h3C);
    apb(1, `LC_FLT_DIS, 32'h0C);
    rc("filter", `LC_FLT_STATE, 32'h30);
  endtask
  task automatic t_level;
    apb(1, `LC_LVL_SET, 32'hFF);
    apb(1, `LC_LVL_CLR, 32'h33);
    apb(1, `LC_LVL_STATE, 32'hFFFF_FFFF);
    rc("level", `LC_LVL_STATE, 32'hCC);
    chk("out", pin_out[7:4], 4'hC);
    apb(1, `LC_DW_EN, 32'h80);
    apb(1, `LC_LVL_STATE, 32'h0);
    rc("level", `LC_LVL_STATE, 32'h4C);
    ext <= 32'h1234_5600;
    repeat (4) @(posedge pclk);
    rc("pins", `LC_PIN_SAMPLE, 32'h1234_5640);
    chk("line", line_in, 32'h1234_5640);
    rc("gap", 8'h0C, 0);
  endtask
  task automatic t_irq;
    apb(1, `LC_GRANT, 32'h100);
    apb(1, `LC_IRQ_EN, 32'h100);
    apb(0, `LC_IRQ_STATUS, 0);
    ext <= ext ^ 32'h100;
    repeat (8) @(posedge pclk);
    chk("irq", irq, 1);
    apb(1, `LC_IRQ_DIS, 32'h100);
    chk("irq", irq, 0);
    rc("mask", `LC_IRQ_MASK, 0);
    apb(1, `LC_IRQ_EN, 32'h100);
    rc("status", `LC_IRQ_STATUS, 32'h100);
    chk("irq", irq, 0);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset;
    t_own;
    t_level;
    t_irq;
    final_report;
  end
  initial begin
    #200000;
    error_cnt++;
    final_report;
  end
endmodule
`default_nettype wire
